// ### pkg/lfd_pkg.sv
// Package with constants for the line frequency divider.
package lfd_pkg;

  localparam int unsigned LFD_MOD_LARGE_DEF = 60;
  localparam int unsigned LFD_MOD_SMALL_DEF = 50;
  localparam int unsigned LFD_CNT_W         = 12;
  localparam logic [11:0] LFD_CNT_RST       = 12'h000;
  localparam int unsigned LFD_SYNC_STAGES   = 2;

endpackage

// ### verilog/lfd_edge_sync.sv
// Two-stage synchroniser with falling-edge detection for the line clock pin.
`timescale 1ns/1ps
module lfd_edge_sync (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } lfd_sync_s;

  lfd_sync_s st;
  lfd_sync_s next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = pin_in;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.sync;
  assign fall_out  = st.prev & ~st.sync;

endmodule

// ### verilog/lfd_divider.sv
// Line frequency divider: counts falling line clock edges and forms the divided output.
//
// How it works
// R1: Count rises by one on each line clock fall while enabled and not cleared.
// R2: With enable low, line clock falls are ignored and the count holds.
// R3: Clear high forces the count to zero, overriding clock and enable.
// R4: Ratio choice low divides by the larger modulus of the variant.
// R5: Ratio choice high divides by the smaller modulus of the variant.
// R6: Enable driver must not drop enable in high phase and raise it in low.
// R7: Enable driver should change enable only during the low clock phase.
// R8: Output is a symmetric square wave for an even modulus; an odd modulus gives one extra high count.
// R9: Count wraps to zero after modulus minus one on the next enabled fall.
`timescale 1ns/1ps
module lfd_divider #(
  parameter int unsigned MOD_LARGE = lfd_pkg::LFD_MOD_LARGE_DEF,
  parameter int unsigned MOD_SMALL = lfd_pkg::LFD_MOD_SMALL_DEF
) (
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          line_clk_in,
  input  wire logic                          count_en_in,
  input  wire logic                          clear_in,
  input  wire logic                          ratio_small_in,
  output logic [lfd_pkg::LFD_CNT_W-1:0]      count_out,
  output logic                               div_out
);

  localparam logic [lfd_pkg::LFD_CNT_W-1:0] MOD_L   = (lfd_pkg::LFD_CNT_W)'(MOD_LARGE);
  localparam logic [lfd_pkg::LFD_CNT_W-1:0] MOD_S   = (lfd_pkg::LFD_CNT_W)'(MOD_SMALL);
  localparam logic [lfd_pkg::LFD_CNT_W-1:0] MOD_MAX = (MOD_L > MOD_S) ? MOD_L : MOD_S;

  typedef struct packed {
    logic [lfd_pkg::LFD_CNT_W-1:0] cnt;
    logic                          en_s1;
    logic                          en_s2;
    logic                          clr_s1;
    logic                          clr_s2;
    logic                          sel_s1;
    logic                          sel_s2;
    logic                          en_hold;
    logic                          div;
  } lfd_state_s;

  lfd_state_s st;
  lfd_state_s next_st;
  logic       line_lvl;
  logic       line_fall;
  logic [lfd_pkg::LFD_CNT_W-1:0] modulus;
  logic [lfd_pkg::LFD_CNT_W-1:0] cnt_inc;

  ////////////////////////////////////////////////////////////////////////////////

  lfd_edge_sync u_line_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (line_clk_in),
    .level_out  (line_lvl),
    .fall_out   (line_fall)
  );

  // Returns the high-half threshold: the output is high for the upper half of the count.
  function automatic logic [lfd_pkg::LFD_CNT_W-1:0] half_of(input logic [lfd_pkg::LFD_CNT_W-1:0] m);
    half_of = m >> 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st        = st;
    next_st.en_s1  = count_en_in;
    next_st.en_s2  = st.en_s1;
    next_st.clr_s1 = clear_in;
    next_st.clr_s2 = st.clr_s1;
    next_st.sel_s1 = ratio_small_in;
    next_st.sel_s2 = st.sel_s1;
    modulus        = st.sel_s2 ? MOD_S : MOD_L; // R4 R5
    cnt_inc        = st.cnt + 1'b1;
    // Enable is sampled while the line clock is low so a drop in the high phase cannot lose or add a count.
    if (!line_lvl) begin
      next_st.en_hold = st.en_s2; // R7 R6
    end
    if (st.clr_s2) begin
      next_st.cnt = lfd_pkg::LFD_CNT_RST; // R3
    end else if (line_fall && st.en_hold) begin
      if (cnt_inc >= modulus) begin
        next_st.cnt = lfd_pkg::LFD_CNT_RST; // R9
      end else begin
        next_st.cnt = cnt_inc; // R1
      end
    end // R2
    next_st.div = (next_st.cnt >= half_of(modulus)); // R8
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_out = st.cnt;
  assign div_out   = st.div;

  ////////////////////////////////////////////////////////////////////////////////

  a_clear_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R3
    st.clr_s2
    |=>
    (st.cnt == '0))
    else $error("Count not zero after clear.");

  a_clear_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R3
    (st.clr_s2 && $past(st.clr_s2))
    |->
    (st.cnt == '0))
    else $error("Count left zero while clear held.");

  a_clear_low_out: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R3
    st.clr_s2
    |=>
    !st.div)
    else $error("Divided output high after clear.");

  a_hold_disabled: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R2
    (!st.en_hold && !st.clr_s2)
    |=>
    $stable(st.cnt))
    else $error("Count moved while disabled.");

  a_step_one: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R1
    (line_fall && st.en_hold && !st.clr_s2 && (cnt_inc < modulus))
    |=>
    (st.cnt == $past(st.cnt) + 1'b1))
    else $error("Count did not step by one.");

  a_no_spurious: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R1
    (!line_fall && !st.clr_s2)
    |=>
    $stable(st.cnt))
    else $error("Count moved without a clock fall.");

  a_fall_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R1
    line_fall
    |=>
    !line_fall)
    else $error("Line clock fall seen twice.");

  a_wrap_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R9
    (line_fall && st.en_hold && !st.clr_s2 && (cnt_inc >= modulus))
    |=>
    (st.cnt == '0))
    else $error("Count did not wrap.");

  a_large_mod: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R4
    (line_fall && st.en_hold && !st.clr_s2 && !st.sel_s2)
    |=>
    (st.cnt == (($past(st.cnt) >= MOD_L - 1'b1) ? '0 : $past(st.cnt) + 1'b1)))
    else $error("Large modulus not kept.");

  a_small_mod: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R5
    (line_fall && st.en_hold && !st.clr_s2 && st.sel_s2)
    |=>
    (st.cnt == (($past(st.cnt) >= MOD_S - 1'b1) ? '0 : $past(st.cnt) + 1'b1)))
    else $error("Small modulus not kept.");

  a_below_mod: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R4 R5
    1'b1
    |->
    (st.cnt < MOD_MAX))
    else $error("Count beyond modulus.");

  a_out_square: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R8
    ##1
    (st.div == (st.cnt >= half_of($past(modulus))) || $changed(st.sel_s2)))
    else $error("Divided output not matching count half.");

  a_div_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R8
    ((st.cnt == '0) && $stable(st.sel_s2))
    |->
    !st.div)
    else $error("Divided output high at count zero.");

  a_div_top: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R8
    ((st.cnt == modulus - 1'b1) && $stable(st.sel_s2))
    |->
    st.div)
    else $error("Divided output low at last count.");

  a_div_steady: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R8
    (!line_fall && !st.clr_s2 && $stable(st.sel_s2))
    |=>
    $stable(st.div))
    else $error("Divided output moved without a count.");

  a_en_sample: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R6
    line_lvl
    |=>
    (st.en_hold == $past(st.en_hold)))
    else $error("Enable sampled in high phase.");

  a_en_low_phase: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R7
    !line_lvl
    |=>
    (st.en_hold == $past(st.en_s2)))
    else $error("Enable not taken in low phase.");

  c_wrap: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    line_fall && st.en_hold && !st.clr_s2 && (cnt_inc >= modulus));

  c_large_wrap: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    line_fall && st.en_hold && !st.clr_s2 && !st.sel_s2 && (cnt_inc >= modulus));

  c_clear: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    st.clr_s2 && (st.cnt != '0));

  c_small: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    st.sel_s2 && $rose(st.div));

  c_hold: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    line_fall && !st.en_hold);

endmodule

// ### verif/lfd_line_src.sv
// Line clock source and count enable driver model.
`timescale 1ns/1ps
module lfd_line_src #(
  parameter int HALF = 16
) (
  input  wire logic clk_in,
  input  wire logic en_req_in,
  output logic      line_clk_out,
  output logic      count_en_out
);
  int cnt = 0;
  initial line_clk_out = 1'b1;
  initial count_en_out = 1'b0;
  always @(posedge clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      line_clk_out <= ~line_clk_out;
    end
    // Enable moves only while the line clock is low.
    if (!line_clk_out) begin
      count_en_out <= en_req_in;
    end
  end
endmodule

// ### verif/tb_top.sv
// Self-checking testbench for the line frequency divider.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
  logic                          clk_in = 1'b0;
  logic                          sys_rst_in = 1'b1;
  logic                          en_req = 1'b0;
  logic                          clear = 1'b0;
  logic                          ratio = 1'b0;
  logic                          line_clk;
  logic                          count_en;
  logic [lfd_pkg::LFD_CNT_W-1:0] count;
  logic                          div;
  int                            fails = 0;
  int                            comparisons = 0;

  lfd_line_src SRC (.clk_in(clk_in), .en_req_in(en_req), .line_clk_out(line_clk), .count_en_out(count_en));
  lfd_divider #(.MOD_LARGE(6), .MOD_SMALL(5)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .line_clk_in(line_clk), .count_en_in(count_en), .clear_in(clear), .ratio_small_in(ratio),
    .count_out(count), .div_out(div));

  ////////////////////////////////////////////////////////////////////////////
  task automatic falls(input int n);
    repeat (n) @(negedge line_clk);
    repeat (6) @(posedge clk_in);
  endtask
  task automatic t_count;
    @(negedge line_clk);
    repeat (2) @(posedge clk_in);
    en_req <= 1'b1;
    falls(4);
    `CHK(count, 12'h004)
    `CHK(div, 1'b1)
  endtask
  task automatic t_hold;
    en_req <= 1'b0;
    falls(3);
    `CHK(count, 12'h004)
    en_req <= 1'b1;
    falls(2);
    `CHK(count, 12'h000)
    `CHK(div, 1'b0)
  endtask
  task automatic t_small;
    ratio <= 1'b1;
    falls(2);
    `CHK(count, 12'h002)
    `CHK(div, 1'b1)
    falls(3);
    `CHK(count, 12'h000)
  endtask
  task automatic t_clear;
    falls(2);
    clear <= 1'b1;
    falls(2);
    `CHK(count, 12'h000)
    clear <= 1'b0;
    falls(1);
    `CHK(count, 12'h001)
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial forever #25 clk_in = ~clk_in;
  initial begin
    #100us;
    fails++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_count;
    t_hold;
    t_small;
    t_clear;
    results;
  end
endmodule
